// file: css_scan_seq.sv
// channel scan sequencer top: apb registers, relay map and scan state machine
`timescale 1ns/1ps
`default_nettype none
module css_scan_seq (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reading_done,
  output logic             meas_start,
  output logic             store_strobe,
  output logic      [31:0] relay_close,
  output logic      [1:0]  function_sel
);
  css_mem_if mif ();

  css_list_mem u_mem (
    .pclk (pclk),
    .mif  (mif)
  );

  function automatic logic chan_valid(input logic [4:0] ch, input logic [1:0] fn);
    logic ok;
    ok = 1'b0;
    case (fn)
      css_pkg::FUNC_AMPS: ok = (ch >= css_pkg::CH_AMP_MIN) && (ch <= css_pkg::CH_AMP_MAX);
      css_pkg::FUNC_RES4: ok = (ch >= css_pkg::CH_MIN) && (ch <= css_pkg::CH_PAIR_MAX);
      default:            ok = (ch >= css_pkg::CH_MIN) && (ch <= css_pkg::CH_V_MAX);
    endcase
    return ok;
  endfunction

  function automatic logic [13:0] clamp_count(input logic [31:0] v);
    logic [13:0] r;
    r = v[13:0];
    if (v < 32'(css_pkg::COUNT_MIN))
      r = css_pkg::COUNT_MIN;
    else if (v > 32'(css_pkg::COUNT_MAX))
      r = css_pkg::COUNT_MAX;
    return r;
  endfunction

  // apb decode; every transfer takes one wait cycle so list reads come from a register
  // writes land on the completing edge, the one at which the master sees pready high
  logic        acc;
  logic        wr_acc;
  logic        hit_list;
  logic        hit_reg;
  logic        mapped;
  logic [7:0]  roff;
  assign acc      = psel && penable && !pready;
  assign wr_acc   = psel && penable && pready && pwrite;
  assign roff     = {paddr[7:2], 2'b00};
  assign hit_list = (roff >= css_pkg::LIST_OFF);
  assign hit_reg  = (roff <= css_pkg::STORED_OFF);
  assign mapped   = hit_list || hit_reg;

  logic        list_sel_reg;
  logic        step_reg;
  logic        pinf_reg;
  logic [1:0]  func_reg;
  logic [23:0] rdg_reg;
  logic [13:0] pass_cnt_reg;
  logic [13:0] chcnt_reg;
  logic [31:0] intv_reg;
  logic [4:0]  len_reg;
  logic [4:0]  chan_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  logic        w_ctrl;
  logic        w_cmd;
  logic        cmd_init;
  logic        cmd_open;
  logic        cmd_close;
  logic        cmd_restore;
  assign w_ctrl      = wr_acc && (roff == css_pkg::CTRL_OFF);
  assign w_cmd       = wr_acc && (roff == css_pkg::CMD_OFF);
  assign cmd_init    = w_cmd && pwdata[css_pkg::INIT_BIT];
  assign cmd_open    = w_cmd && pwdata[css_pkg::OPEN_BIT];
  assign cmd_close   = w_cmd && pwdata[css_pkg::CLOSE_BIT];
  assign cmd_restore = w_cmd && pwdata[css_pkg::RESTORE_BIT];

  assign mif.wr_en   = wr_acc && hit_list;
  assign mif.wr_addr = paddr[5:2];
  assign mif.wr_data = pwdata[4:0];
  assign mif.a_addr  = paddr[5:2];

  // reading done arrives from the meter side, so it is synchronised first
  logic done_s1_reg;
  logic done_s2_reg;
  logic done_d_reg;
  logic done_edge;
  assign done_edge = done_s2_reg && !done_d_reg;

  css_pkg::css_state_type state_reg;
  css_pkg::css_state_type state_next;
  logic [3:0]  entry_reg;
  logic [3:0]  entry_next;
  logic [13:0] cip_reg;
  logic [13:0] cip_next;
  logic [13:0] pass_reg;
  logic [13:0] pass_next;
  logic [23:0] stored_reg;
  logic [23:0] stored_next;
  logic [31:0] timer_reg;
  logic        tick_reg;
  logic        meas_reg;
  logic        store_reg;
  logic [31:0] relay_reg;

  logic        busy;
  logic        start_go;
  logic        abort;
  logic        last_in_pass;
  logic        runs_out;
  logic        intv_done;
  logic        tick_take;
  logic        seq_close;
  assign busy         = (state_reg != css_pkg::ST_IDLE);
  assign start_go     = !busy && list_sel_reg && cmd_init;
  assign abort        = busy && (!list_sel_reg || cmd_restore);
  assign last_in_pass = (5'(entry_reg) + 5'h01 >= len_reg) || (cip_reg + 14'h0001 >= chcnt_reg);
  assign runs_out     = !pinf_reg && (pass_reg + 14'h0001 >= pass_cnt_reg);
  assign intv_done    = (intv_reg == 32'h00000000) || tick_reg;
  assign tick_take    = (state_reg == css_pkg::ST_INTV) && intv_done;
  assign seq_close    = (state_reg == css_pkg::ST_CLOSE) && chan_valid(mif.b_data, func_reg);
  assign mif.b_addr   = entry_reg;

  always_comb
  begin
    state_next  = state_reg;
    entry_next  = entry_reg;
    cip_next    = cip_reg;
    pass_next   = pass_reg;
    stored_next = stored_reg;
    case (state_reg)
      css_pkg::ST_IDLE:
      begin
        if (start_go)
        begin
          entry_next  = 4'h0;
          cip_next    = 14'h0000;
          pass_next   = 14'h0000;
          stored_next = 24'h000000;
          state_next  = css_pkg::ST_LOAD;
        end
      end
      css_pkg::ST_LOAD:  state_next = css_pkg::ST_CLOSE;
      css_pkg::ST_CLOSE: state_next = seq_close ? css_pkg::ST_WAIT : css_pkg::ST_ADV;
      css_pkg::ST_WAIT:
      begin
        if (done_edge)
        begin
          stored_next = stored_reg + 24'h000001;
          state_next  = (stored_next >= rdg_reg) ? css_pkg::ST_IDLE : css_pkg::ST_ADV;
        end
      end
      css_pkg::ST_ADV:
      begin
        if (last_in_pass)
        begin
          entry_next = 4'h0;
          cip_next   = 14'h0000;
          pass_next  = pass_reg + 14'h0001;
          state_next = runs_out ? css_pkg::ST_IDLE : css_pkg::ST_INTV;
        end
        else
        begin
          entry_next = entry_reg + 4'h1;
          cip_next   = cip_reg + 14'h0001;
          state_next = step_reg ? css_pkg::ST_INTV : css_pkg::ST_LOAD;
        end
      end
      css_pkg::ST_INTV:  state_next = intv_done ? css_pkg::ST_LOAD : css_pkg::ST_INTV;
      default:           state_next = css_pkg::ST_IDLE;
    endcase
    if (abort)
    begin
      state_next = css_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg  <= css_pkg::ST_IDLE;
      entry_reg  <= 4'h0;
      cip_reg    <= 14'h0000;
      pass_reg   <= 14'h0000;
      stored_reg <= 24'h000000;
      store_reg  <= 1'b0;
      meas_reg   <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      entry_reg  <= entry_next;
      cip_reg    <= cip_next;
      pass_reg   <= pass_next;
      stored_reg <= stored_next;
      store_reg  <= (state_reg == css_pkg::ST_WAIT) && done_edge && !abort;
      meas_reg   <= seq_close && !abort;
    end
  end

  // timer from launch; set wins over the interval state's take
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_reg <= css_pkg::TIMER_RST;
      tick_reg  <= 1'b0;
    end
    else if (start_go || !busy)
    begin
      timer_reg <= intv_reg;
      tick_reg  <= 1'b0;
    end
    else if (timer_reg <= 32'h00000001)
    begin
      timer_reg <= intv_reg;
      tick_reg  <= 1'b1;
    end
    else
    begin
      timer_reg <= timer_reg - 32'h00000001;
      tick_reg  <= tick_reg && !tick_take;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_d_reg  <= 1'b0;
    end
    else
    begin
      done_s1_reg <= reading_done;
      done_s2_reg <= done_s1_reg;
      done_d_reg  <= done_s2_reg;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      list_sel_reg <= 1'b0;
      step_reg     <= 1'b0;
      pinf_reg     <= 1'b0;
      func_reg     <= css_pkg::FUNC_DC_VOLT;
      rdg_reg      <= css_pkg::RDG_RST;
      pass_cnt_reg <= css_pkg::PASS_RST;
      chcnt_reg    <= css_pkg::CHCNT_RST;
      intv_reg     <= css_pkg::TIMER_RST;
      len_reg      <= css_pkg::LEN_RST;
    end
    else if (cmd_restore)
    begin
      list_sel_reg <= 1'b0;
      func_reg     <= css_pkg::FUNC_DC_VOLT;
      pass_cnt_reg <= css_pkg::PASS_RST;
    end
    else if (wr_acc)
    begin
      if (w_ctrl)
      begin
        list_sel_reg <= pwdata[css_pkg::LIST_SEL_BIT];
        step_reg <= pwdata[css_pkg::STEP_BIT];
        pinf_reg <= pwdata[css_pkg::PINF_BIT];
        func_reg <= pwdata[css_pkg::FUNC_LSB +: 2];
      end
      if (roff == css_pkg::RDG_OFF)
        rdg_reg <= (pwdata[23:0] == 24'h000000) ? css_pkg::RDG_RST : pwdata[23:0];
      if (roff == css_pkg::PASS_OFF)
        pass_cnt_reg <= clamp_count(pwdata);
      if (roff == css_pkg::CHCNT_OFF)
        chcnt_reg <= clamp_count(pwdata);
      if (roff == css_pkg::TIMER_OFF)
        intv_reg <= pwdata;
      if (roff == css_pkg::LEN_OFF)
        len_reg <= (pwdata[4:0] == 5'h00 || pwdata[4:0] > css_pkg::LEN_MAX) ?
                   css_pkg::LEN_MAX : pwdata[4:0];
    end
  end

  // single closed input channel, new one replaces the old
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan_reg <= 5'h00;
    else if (cmd_restore || cmd_open)
      chan_reg <= 5'h00;
    else if (seq_close && !abort)
      chan_reg <= mif.b_data;
    else if (cmd_close && !busy)
      chan_reg <= pwdata[css_pkg::CMD_CH_LSB +: 5];
  end

  logic        pair_on;
  logic [4:0]  pair_ch;
  logic [31:0] relay_next;
  assign pair_on    = (func_reg == css_pkg::FUNC_RES4) && (chan_reg >= css_pkg::CH_MIN) &&
                      (chan_reg <= css_pkg::CH_PAIR_MAX);
  assign pair_ch    = chan_reg + css_pkg::PAIR_OFFSET;
  assign relay_next = ((chan_reg == 5'h00) ? 32'h00000000 : (32'h00000001 << chan_reg)) |
                      (pair_on ? (32'h00000001 << pair_ch) : 32'h00000000);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      relay_reg <= 32'h00000000;
    else
      relay_reg <= relay_next;
  end

  logic [31:0] rd_mux;
  assign rd_mux =
    hit_list ? {27'h0000000, mif.a_data} :
    (roff == css_pkg::CTRL_OFF)   ? {23'h000000, pinf_reg, 2'b00, func_reg, 2'b00, step_reg,
                                     list_sel_reg} :
    (roff == css_pkg::RDG_OFF)    ? {8'h00, rdg_reg} :
    (roff == css_pkg::PASS_OFF)   ? {18'h00000, pass_cnt_reg} :
    (roff == css_pkg::CHCNT_OFF)  ? {18'h00000, chcnt_reg} :
    (roff == css_pkg::TIMER_OFF)  ? intv_reg :
    (roff == css_pkg::LEN_OFF)    ? {27'h0000000, len_reg} :
    (roff == css_pkg::STATUS_OFF) ? {23'h000000, busy, 3'b000, chan_reg} :
    (roff == css_pkg::STORED_OFF) ? {8'h00, stored_reg} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end
    else
    begin
      pready_reg  <= acc;
      pslverr_reg <= acc && !mapped;
      prdata_reg  <= (acc && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign meas_start   = meas_reg;
  assign store_strobe = store_reg;
  assign relay_close  = relay_reg;
  assign function_sel = func_reg;

  a_store_bound: assert property (@(posedge pclk) disable iff (!presetn)
    store_reg |-> (stored_reg != 24'h000000) && (stored_reg <= rdg_reg))
    else $error("reading stored beyond reading count");
  a_halt_done: assert property (@(posedge pclk) disable iff (!presetn)
    store_reg && (stored_reg == rdg_reg) |-> !busy ##1 !busy)
    else $error("sequencer still running after last reading");
  a_one_input: assert property (@(posedge pclk) disable iff (!presetn)
    $countones(relay_reg) <= 2)
    else $error("more than one input channel closed");
  a_pair_close: assert property (@(posedge pclk) disable iff (!presetn)
    pair_on |=> (relay_reg == ((32'h00000001 << $past(chan_reg)) |
                               (32'h00000001 << $past(pair_ch)))))
    else $error("four-wire sense channel not closed with its pair");
  a_valid_chan: assert property (@(posedge pclk) disable iff (!presetn)
    meas_reg |-> chan_valid(chan_reg, func_reg) || !$stable(func_reg))
    else $error("measurement on a channel invalid for the function");
  a_abort_stop: assert property (@(posedge pclk) disable iff (!presetn)
    busy && !list_sel_reg |=> !busy ##1 !store_reg)
    else $error("scan kept running with list select off");
  a_need_init: assert property (@(posedge pclk) disable iff (!presetn)
    !busy && !start_go |=> !busy)
    else $error("scan started without an initiate command");
  a_timer_launch: assert property (@(posedge pclk) disable iff (!presetn)
    start_go |=> (timer_reg == $past(intv_reg)) && !tick_reg)
    else $error("interval timer not loaded at launch");
  a_intv_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == css_pkg::ST_INTV) && !intv_done && list_sel_reg && !cmd_restore
    |=> state_reg == css_pkg::ST_INTV)
    else $error("pass started before interval expired");
  a_restore_def: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_restore |=> (func_reg == css_pkg::FUNC_DC_VOLT) && (pass_cnt_reg == css_pkg::PASS_RST)
                    && (chan_reg == 5'h00) ##1 (relay_reg == 32'h00000000))
    else $error("defaults not restored");
  a_count_range: assert property (@(posedge pclk) disable iff (!presetn)
    (pass_cnt_reg >= css_pkg::COUNT_MIN) && (pass_cnt_reg <= css_pkg::COUNT_MAX) &&
    (chcnt_reg >= css_pkg::COUNT_MIN) && (chcnt_reg <= css_pkg::COUNT_MAX))
    else $error("pass or channel count out of range");

  c_launch: cover property (@(posedge pclk) disable iff (!presetn) start_go);
  c_second_pass: cover property (@(posedge pclk) disable iff (!presetn)
    busy && (pass_reg == 14'h0001) && store_reg);
  c_four_wire: cover property (@(posedge pclk) disable iff (!presetn) pair_on && busy);
  c_finish: cover property (@(posedge pclk) disable iff (!presetn)
    store_reg && (stored_reg == rdg_reg));
endmodule
`default_nettype wire

// file: css_pkg.sv
// shared constants and types for the channel scan sequencer
package css_pkg;
  localparam int          CHAN_W        = 5;
  localparam int          LIST_DEPTH    = 16;
  localparam int          LIST_AW       = 4;
  localparam int          COUNT_W       = 14;
  localparam int          RDG_W         = 24;
  localparam int          TIMER_W       = 32;
  // register byte offsets
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  CMD_OFF       = 8'h04;
  localparam logic [7:0]  RDG_OFF       = 8'h08;
  localparam logic [7:0]  PASS_OFF      = 8'h0c;
  localparam logic [7:0]  CHCNT_OFF     = 8'h10;
  localparam logic [7:0]  TIMER_OFF     = 8'h14;
  localparam logic [7:0]  LEN_OFF       = 8'h18;
  localparam logic [7:0]  STATUS_OFF    = 8'h1c;
  localparam logic [7:0]  STORED_OFF    = 8'h20;
  localparam logic [7:0]  LIST_OFF      = 8'h40;
  // control, command and status field positions
  localparam int          LIST_SEL_BIT  = 0;
  localparam int          STEP_BIT      = 1;
  localparam int          FUNC_LSB      = 4;
  localparam int          PINF_BIT      = 8;
  localparam int          INIT_BIT      = 0;
  localparam int          OPEN_BIT      = 1;
  localparam int          CLOSE_BIT     = 2;
  localparam int          RESTORE_BIT   = 3;
  localparam int          CMD_CH_LSB    = 8;
  localparam int          BUSY_BIT      = 8;
  // measurement functions
  localparam logic [1:0]  FUNC_DC_VOLT  = 2'h0;
  localparam logic [1:0]  FUNC_RES2     = 2'h1;
  localparam logic [1:0]  FUNC_RES4     = 2'h2;
  localparam logic [1:0]  FUNC_AMPS     = 2'h3;
  // channel ranges and pairing
  localparam logic [4:0]  CH_MIN        = 5'h01;
  localparam logic [4:0]  CH_PAIR_MAX   = 5'h0a;
  localparam logic [4:0]  CH_V_MAX      = 5'h14;
  localparam logic [4:0]  CH_AMP_MIN    = 5'h15;
  localparam logic [4:0]  CH_AMP_MAX    = 5'h16;
  localparam logic [4:0]  PAIR_OFFSET   = 5'h0a;
  // count limits and values after reset
  localparam logic [13:0] COUNT_MIN     = 14'h0001;
  localparam logic [13:0] COUNT_MAX     = 14'h2af8;
  localparam logic [13:0] PASS_RST      = 14'h0001;
  localparam logic [13:0] CHCNT_RST     = 14'h0001;
  localparam logic [23:0] RDG_RST       = 24'h000001;
  localparam logic [31:0] TIMER_RST     = 32'h00000000;
  localparam logic [4:0]  LEN_RST       = 5'h01;
  localparam logic [4:0]  LEN_MAX       = 5'h10;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_LOAD  = 6'b000010,
    ST_CLOSE = 6'b000100,
    ST_WAIT  = 6'b001000,
    ST_ADV   = 6'b010000,
    ST_INTV  = 6'b100000
  } css_state_type;
endpackage

// file: css_mem_if.sv
// channel list memory connection between sequencer and its list store
`timescale 1ns/1ps
`default_nettype none
interface css_mem_if;
  logic       wr_en;
  logic [3:0] wr_addr;
  logic [4:0] wr_data;
  logic [3:0] a_addr;
  logic [4:0] a_data;
  logic [3:0] b_addr;
  logic [4:0] b_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output a_addr, output b_addr,
                input a_data, input b_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input a_addr, input b_addr,
                output a_data, output b_data);
endinterface
`default_nettype wire

// file: css_list_mem.sv
// scan list store: one write port, two registered read ports
`timescale 1ns/1ps
`default_nettype none
module css_list_mem (
  input  wire logic pclk,
  css_mem_if.mem    mif
);
  logic [4:0] store_reg [0:15];
  logic [4:0] a_reg;
  logic [4:0] b_reg;

  // no reset on the array; entries are defined by software before a launch
  always_ff @(posedge pclk)
  begin
    if (mif.wr_en)
    begin
      store_reg[mif.wr_addr] <= mif.wr_data;
    end
    a_reg <= store_reg[mif.a_addr];
    b_reg <= store_reg[mif.b_addr];
  end

  assign mif.a_data = a_reg;
  assign mif.b_data = b_reg;
endmodule
`default_nettype wire

// file: css_meter_model.sv
// meter stand-in: answers each measurement start with one finished-reading pulse
`timescale 1ns/1ps
`default_nettype none
module css_meter_model (
  input  wire logic       pclk,
  input  wire logic       meas_start,
  input  wire logic [3:0] delay,
  output var  logic       reading_done
);
  initial
  begin
    reading_done = 1'b0;
    forever
    begin
      @(posedge pclk);
      if (meas_start === 1'b1)
      begin
        repeat (delay) @(posedge pclk);
        reading_done <= 1'b1;
        // two cycles high, two low: the pin passes a two-stage synchroniser
        repeat (2) @(posedge pclk);
        reading_done <= 1'b0;
        repeat (2) @(posedge pclk);
      end
    end
  end
endmodule
`default_nettype wire

// file: test_channel_scan_sequencer.sv
// self-checking bench for the channel scan sequencer
`timescale 1ns/1ps
`default_nettype none
module test_channel_scan_sequencer;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        reading_done;
  logic        meas_start;
  logic        store_strobe;
  logic [31:0] relay_close;
  logic [1:0]  function_sel;
  logic [3:0]  dly;
  logic [31:0] rd;
  logic        er;
  int          failures;
  int          tests_run;
  int          n_meas;
  int          n_store;
  int          cyc;
  int          last_ms;
  int          first_ms;
  int          min_gap;
  int          max_gap;
  int          rc;
  int          p;
  int          w;

  css_scan_seq css_scan_seq_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reading_done(reading_done), .meas_start(meas_start), .store_strobe(store_strobe),
    .relay_close(relay_close), .function_sel(function_sel)
  );
  css_meter_model css_meter_model_inst (
    .pclk(pclk), .meas_start(meas_start), .delay(dly), .reading_done(reading_done)
  );

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (store_strobe === 1'b1)
      n_store++;
    if (meas_start === 1'b1)
    begin
      if (n_meas == 0)
        first_ms = cyc;
      else if (cyc - last_ms < min_gap)
        min_gap = cyc - last_ms;
      if (n_meas > 0 && cyc - last_ms > max_gap)
        max_gap = cyc - last_ms;
      last_ms = cyc;
      n_meas++;
    end
  end

  task automatic conclude;
    $display("counts: tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one apb transfer, then one idle cycle so strobes never change twice in a step
  task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_n;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      conclude();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, css_pkg::STATUS_OFF, 32'h0);
      n++;
    end
    while (rd[css_pkg::BUSY_BIT] !== 1'b0 && n < 300);
    if (n >= 300)
    begin
      failures++;
      conclude();
    end
  endtask

  task automatic launch(input logic [31:0] c, r, pc, t, len);
    wr(css_pkg::RDG_OFF, r);
    wr(css_pkg::PASS_OFF, pc);
    wr(css_pkg::TIMER_OFF, t);
    wr(css_pkg::LEN_OFF, len);
    wr(css_pkg::CHCNT_OFF, len);
    wr(css_pkg::CTRL_OFF, c);
    n_meas = 0;
    n_store = 0;
    min_gap = 99999;
    max_gap = 0;
    wr(css_pkg::CMD_OFF, 32'h1);
  endtask

  function automatic int exp_store(int r, int pc, int len);
    return (r < pc * len) ? r : pc * len;
  endfunction

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dly = 4'h2;
    void'($urandom(32'hd0d4));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(css_pkg::CTRL_OFF, 32'h0);
    rdc(css_pkg::PASS_OFF, 32'h1);
    chk(relay_close, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(css_pkg::PASS_OFF, 32'h0);
    rdc(css_pkg::PASS_OFF, 32'h1);
    wr(css_pkg::PASS_OFF, 32'h2af9);
    rdc(css_pkg::PASS_OFF, 32'h2af8);
    wr(css_pkg::CHCNT_OFF, 32'h0);
    rdc(css_pkg::CHCNT_OFF, 32'h1);
    wr(css_pkg::CHCNT_OFF, 32'h2af8);
    rdc(css_pkg::CHCNT_OFF, 32'h2af8);
    n_meas = 0;
    wr(css_pkg::CMD_OFF, 32'h1);
    repeat (10) @(posedge pclk);
    rdc(css_pkg::STATUS_OFF, 32'h0);
    chk(32'(n_meas), 32'h0);
    done("registers");
    for (int i = 0; i < 4; i++)
      wr(css_pkg::LIST_OFF + 8'(4 * i), 32'(i + 1));
    for (int k = 0; k < 4; k++)
    begin
      rc = 1 + $urandom % 9;
      p = (rc + 3) / 4 - k % 2;
      if (p < 1)
        p = 1;
      dly <= 4'($urandom % 8);
      launch((k == 3) ? 32'h101 : 32'h1, 32'(rc), 32'(p), 32'h0, 32'h4);
      if (k == 3)
        p = 99;
      wait_idle();
      chk(32'(n_store), 32'(exp_store(rc, p, 4)));
      chk(32'(n_meas), 32'(exp_store(rc, p, 4)));
      rdc(css_pkg::STORED_OFF, 32'(exp_store(rc, p, 4)));
    end
    done("random scans");
    dly <= 4'h2;
    launch(32'h1, 32'h4, 32'h2, 32'd60, 32'h2);
    wait_idle();
    chk(32'(n_store), 32'h4);
    chk(32'(max_gap >= 40), 32'h1);
    chk(32'(last_ms - first_ms <= 80), 32'h1);
    launch(32'h3, 32'h5, 32'h2af8, 32'd40, 32'h4);
    wait_idle();
    chk(32'(n_meas), 32'h5);
    chk(32'(n_store), 32'h5);
    chk(32'(min_gap >= 36), 32'h1);
    done("interval");
    wr(css_pkg::CMD_OFF, 32'h2);
    @(posedge pclk);
    chk(relay_close, 32'h0);
    wr(css_pkg::CTRL_OFF, 32'h10);
    wr(css_pkg::CMD_OFF, 32'h0604);
    repeat (3) @(posedge pclk);
    chk(relay_close, 32'h40);
    wr(css_pkg::CTRL_OFF, 32'h20);
    repeat (3) @(posedge pclk);
    chk(relay_close, 32'h10040);
    wr(css_pkg::CMD_OFF, 32'h0304);
    repeat (3) @(posedge pclk);
    chk(relay_close, 32'h2008);
    wr(css_pkg::CTRL_OFF, 32'h121);
    wr(css_pkg::CMD_OFF, 32'h8);
    repeat (3) @(posedge pclk);
    chk(relay_close, 32'h0);
    chk({30'h0, function_sel}, 32'h0);
    rdc(css_pkg::PASS_OFF, 32'h1);
    apb(1'b0, css_pkg::CTRL_OFF, 32'h0);
    chk(rd & 32'h31, 32'h0);
    done("relays");
    wr(css_pkg::LIST_OFF, 32'h5);
    wr(css_pkg::LIST_OFF + 8'h04, 32'h15);
    launch(32'h31, 32'h2, 32'h1, 32'h0, 32'h2);
    wait_idle();
    chk(32'(n_meas), 32'h1);
    chk(relay_close, 32'h00200000);
    launch(32'h3, 32'h5, 32'h2af8, 32'd200, 32'h1);
    w = 0;
    while (n_store < 1 && w < 200)
    begin
      @(posedge pclk);
      w++;
    end
    if (w >= 200)
    begin
      failures++;
      conclude();
    end
    wr(css_pkg::CTRL_OFF, 32'h2);
    repeat (300) @(posedge pclk);
    chk(32'(n_store), 32'h1);
    apb(1'b0, css_pkg::STATUS_OFF, 32'h0);
    chk({31'h0, rd[css_pkg::BUSY_BIT]}, 32'h0);
    done("abort");
    conclude();
  end
endmodule
`default_nettype wire
